/* design/pdma_attr_assign.sv */
// attribute assignment stage for inbound pcie dma requests
`timescale 1ns/1ps
// Behaviour
// - coherent io path joins the same inner shareable domain as processors
// - without io coherency, requests may leave processor caches unsnooped
// - stage order is free if the result equals the sequential flow
// - requests are never merged or altered on intermediate attributes
// - a mode exists where translated attribute hints are ignored
// - every request starts normal, write-back inner and outer, outer shareable
// - processing hint set gives read or write allocate
// - no-snoop set replaces attributes with normal non-cacheable
// - non-cacheable attributes are always outer shareable
// - current attributes go to the system mmu with the request
// - mmu output attributes replace the request attributes wholly
// - target windows may override or ignore assigned attributes
// - msi writes stay ordered after earlier writes on this path
// - msi writes never merge and never allocate in caches while overrideEnable is set
// - peer mmio targets keep pcie rules and region properties
// - io shareability domain holds no cache outside the processors' domain
// - legacy io maps one-to-one onto a host physical window
// - legacy io window is fixed by straps, no driver needed
module pdma_attr_assign #(
    parameter logic [pdma_attr_pkg::ADDR_W-1:0] IO_WINDOW_BASE = 64'h0000_0000_F000_0000,
    parameter logic [pdma_attr_pkg::ADDR_W-1:0] MMIO_BASE = 64'h0000_0000_4000_0000,
    parameter logic [pdma_attr_pkg::ADDR_W-1:0] MMIO_LIMIT = 64'h0000_0000_7FFF_FFFF,
    parameter logic [pdma_attr_pkg::ADDR_W-1:0] MSI_BASE = 64'h0000_0000_0800_0000,
    parameter logic [pdma_attr_pkg::ADDR_W-1:0] MSI_LIMIT = 64'h0000_0000_0800_FFFF
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    // configuration levels
    input wire logic ioCoherent,
    input wire logic mmuPresent,
    input wire logic ignoreHints,
    input wire logic overrideEnable,
    // inbound request
    input wire logic reqValid,
    output logic reqReady,
    input wire pdma_attr_pkg::pdma_req_t reqData,
    // system mmu
    output logic mmuValid,
    output pdma_attr_pkg::pdma_out_t mmuData,
    input wire logic mmuReady,
    input wire logic mmuDone,
    input wire pdma_attr_pkg::pdma_attr_t mmuAttr,
    // towards interconnect
    output logic outValid,
    output pdma_attr_pkg::pdma_out_t outData,
    input wire logic outReady,
    // outstanding posted writes still unacknowledged downstream
    input wire logic writesPending
);

    // ------------------------------------------------------------
    // attribute stages
    // ------------------------------------------------------------

    // non-cacheable anywhere means outer shareable
    // coherency comes in as an argument so a continuous caller
    // re-evaluates whenever the level changes
    function automatic pdma_attr_pkg::pdma_attr_t fixShare(
        input pdma_attr_pkg::pdma_attr_t a,
        input logic coherent
    );
        pdma_attr_pkg::pdma_attr_t r;
        r = a;
        if (a.innerCache == pdma_attr_pkg::CA_NC || a.outerCache == pdma_attr_pkg::CA_NC ||
            a.memType == pdma_attr_pkg::MT_DEVICE) begin
            r.share = pdma_attr_pkg::SH_OUTER;
        end
        // without coherency there is no inner domain to join
        if (!coherent && r.share == pdma_attr_pkg::SH_INNER) begin
            r.share = pdma_attr_pkg::SH_OUTER;
        end
        return r;
    endfunction

    function automatic logic inRange(input logic [pdma_attr_pkg::ADDR_W-1:0] a,
                                     input logic [pdma_attr_pkg::ADDR_W-1:0] lo,
                                     input logic [pdma_attr_pkg::ADDR_W-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // ------------------------------------------------------------
    // target view
    // ------------------------------------------------------------

    // a target that must keep its own properties: device, uncached,
    // outer shareable, never allocated and never merged
    function automatic pdma_attr_pkg::pdma_attr_t targetAttr(
        input pdma_attr_pkg::pdma_attr_t a
    );
        pdma_attr_pkg::pdma_attr_t r;
        r = a;
        r.memType = pdma_attr_pkg::MT_DEVICE;
        r.innerCache = pdma_attr_pkg::CA_NC;
        r.outerCache = pdma_attr_pkg::CA_NC;
        r.share = pdma_attr_pkg::SH_OUTER;
        // allocation would let an interrupt write linger in a cache
        r.readAlloc = 1'b0;
        r.writeAlloc = 1'b0;
        r.noMerge = 1'b1;
        return r;
    endfunction

    pdma_attr_pkg::pdma_attr_t initAttr;
    pdma_attr_pkg::pdma_attr_t snoopAttr;
    pdma_attr_pkg::pdma_attr_t preMmu;
    pdma_attr_pkg::pdma_attr_t postMmu;
    pdma_attr_pkg::pdma_attr_t finalAttr;
    pdma_attr_pkg::pdma_out_t held;
    pdma_attr_pkg::pdma_out_t next_held;
    pdma_attr_pkg::pdma_state_t state;
    pdma_attr_pkg::pdma_state_t next_state;
    logic isWrite;
    logic isMsi;
    logic hitMsi;
    logic hitMmio;
    logic msiBlocked;
    logic [pdma_attr_pkg::ADDR_W-1:0] mappedAddr;
    logic [pdma_attr_pkg::ADDR_W-1:0] ioOffset;
    logic msiTarget;
    logic mmioTarget;

    // ------------------------------------------------------------
    // initial attributes
    // ------------------------------------------------------------

    // initial stage; translated hints only alter anything when not ignored
    // a hint replaces the whole word, allocation bits included;
    // in the ignore mode the plain initial and hint results stand
    always_comb begin
        initAttr = pdma_attr_pkg::ATTR_INIT;
        initAttr.readAlloc = reqData.procHint && (reqData.kind == pdma_attr_pkg::KIND_READ);
        initAttr.writeAlloc = reqData.procHint && (reqData.kind != pdma_attr_pkg::KIND_READ);
        if (reqData.translated && reqData.hintValid && !ignoreHints) begin
            initAttr = reqData.hintAttr;
        end
    end

    // ------------------------------------------------------------
    // no-snoop override
    // ------------------------------------------------------------

    // no-snoop override replaces type and cacheability
    // allocation hints survive: only type and cacheability are named
    always_comb begin
        snoopAttr = initAttr;
        if (reqData.noSnoop) begin
            snoopAttr.memType = pdma_attr_pkg::MT_NORMAL;
            snoopAttr.innerCache = pdma_attr_pkg::CA_NC;
            snoopAttr.outerCache = pdma_attr_pkg::CA_NC;
        end
    end

    assign preMmu = fixShare(snoopAttr, ioCoherent);

    // ------------------------------------------------------------
    // legacy io
    // ------------------------------------------------------------

    // legacy io is a plain offset into a fixed window, no setup needed
    assign ioOffset = {{(pdma_attr_pkg::ADDR_W-pdma_attr_pkg::IO_W){1'b0}},
        reqData.addr[pdma_attr_pkg::IO_W-1:0]};
    assign mappedAddr = (reqData.kind == pdma_attr_pkg::KIND_IO) ?
        (IO_WINDOW_BASE | ioOffset) : reqData.addr;

    // ------------------------------------------------------------
    // mmu stage
    // ------------------------------------------------------------

    // mmu replaces everything; translated requests bypass it
    // outside the mmu cycle the held word stands: the pre-mmu result, or the mmu answer once taken
    assign postMmu = (state == pdma_attr_pkg::PDMA_MMU) ? mmuAttr : held.attr;

    // ------------------------------------------------------------
    // target decode
    // ------------------------------------------------------------

    assign isMsi = held.kind == pdma_attr_pkg::KIND_MSI;
    assign isWrite = held.kind != pdma_attr_pkg::KIND_READ;
    assign hitMsi = isMsi || (isWrite && inRange(held.addr, MSI_BASE, MSI_LIMIT));
    assign hitMmio = inRange(held.addr, MMIO_BASE, MMIO_LIMIT);

    // msi decode wins so a write into both windows stays an interrupt
    assign msiTarget = overrideEnable && hitMsi;
    assign mmioTarget = overrideEnable && hitMmio && !hitMsi;

    // ------------------------------------------------------------
    // target overrides
    // ------------------------------------------------------------

    // target overrides are last so they win over the mmu
    always_comb begin
        finalAttr = fixShare(postMmu, ioCoherent);
        if (msiTarget) begin
            finalAttr = targetAttr(finalAttr);
        end else if (mmioTarget) begin
            // bar windows keep device ordering whatever the earlier stages said
            finalAttr = targetAttr(finalAttr);
        end
        // coherent domain must never see non-shareable attributes from io
        if (ioCoherent && finalAttr.share == pdma_attr_pkg::SH_NON) begin
            finalAttr.share = pdma_attr_pkg::SH_INNER;
        end
    end

    // ------------------------------------------------------------
    // request sequencing
    // ------------------------------------------------------------

    // one request in flight: nothing can be merged before attributes settle
    // this costs throughput, traded for a path with no reordering hazard
    assign reqReady = (state == pdma_attr_pkg::PDMA_IDLE);
    assign mmuValid = (state == pdma_attr_pkg::PDMA_MMU);
    assign mmuData = held;
    // msi waits until every earlier write has drained
    // the wait is combinational so the flag is honoured the same cycle
    assign msiBlocked = hitMsi && writesPending;
    assign outValid = (state == pdma_attr_pkg::PDMA_OUT) && !msiBlocked;

    always_comb begin
        next_state = state;
        next_held = held;
        case (state)
            pdma_attr_pkg::PDMA_IDLE: begin
                if (reqValid) begin
                    next_held.kind = reqData.kind;
                    next_held.addr = mappedAddr;
                    next_held.tag = reqData.tag;
                    next_held.attr = preMmu;
                    // translated requests are not re-translated
                    if (mmuPresent && !reqData.translated) begin
                        next_state = pdma_attr_pkg::PDMA_MMU;
                    end else begin
                        next_state = pdma_attr_pkg::PDMA_OUT;
                    end
                end
            end
            pdma_attr_pkg::PDMA_MMU: begin
                // mmu may take several cycles; the answer is taken in the cycle with mmuReady together with mmuDone
                if (mmuReady && mmuDone) begin
                    next_held.attr = postMmu;
                    next_state = pdma_attr_pkg::PDMA_OUT;
                end
            end
            pdma_attr_pkg::PDMA_OUT: begin
                // outValid already folds in the msi wait
                if (outValid && outReady) begin
                    next_state = pdma_attr_pkg::PDMA_IDLE;
                end
            end
            default: begin
                // unused code falls back to idle
                next_state = pdma_attr_pkg::PDMA_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= pdma_attr_pkg::PDMA_IDLE;
            held <= '0;
        end else begin
            state <= next_state;
            held <= next_held;
        end
    end

    // ------------------------------------------------------------
    // output register
    // ------------------------------------------------------------

    // final attributes registered so data stays stable under back-pressure
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            outData <= '0;
        end else begin
            outData.kind <= held.kind;
            outData.addr <= held.addr;
            outData.tag <= held.tag;
            outData.attr <= finalAttr;
        end
    end

endmodule

/* design/pdma_attr_pkg.sv */
// shared types and constants for the inbound dma attribute assignment block
package pdma_attr_pkg;

    // memory types
    localparam logic [1:0] MT_DEVICE = 2'h0;
    localparam logic [1:0] MT_NORMAL = 2'h1;

    // cacheability codes
    localparam logic [1:0] CA_NC = 2'h0;
    localparam logic [1:0] CA_WT = 2'h1;
    localparam logic [1:0] CA_WB = 2'h2;

    // shareability codes
    localparam logic [1:0] SH_NON = 2'h0;
    localparam logic [1:0] SH_INNER = 2'h1;
    localparam logic [1:0] SH_OUTER = 2'h2;

    // request kinds
    localparam logic [1:0] KIND_READ = 2'h0;
    localparam logic [1:0] KIND_WRITE = 2'h1;
    localparam logic [1:0] KIND_MSI = 2'h2;
    localparam logic [1:0] KIND_IO = 2'h3;

    localparam int ADDR_W = 64;
    localparam int IO_W = 32;
    localparam int TAG_W = 8;

    typedef struct packed {
        logic [1:0] memType;
        logic [1:0] innerCache;
        logic [1:0] outerCache;
        logic [1:0] share;
        logic readAlloc;
        logic writeAlloc;
        logic noMerge;
    } pdma_attr_t;

    localparam pdma_attr_t ATTR_INIT = '{MT_NORMAL, CA_WB, CA_WB, SH_OUTER,
        1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [1:0] kind;
        logic [ADDR_W-1:0] addr;
        logic [TAG_W-1:0] tag;
        logic noSnoop;
        logic procHint;
        logic translated;
        logic hintValid;
        pdma_attr_t hintAttr;
    } pdma_req_t;

    typedef struct packed {
        logic [1:0] kind;
        logic [ADDR_W-1:0] addr;
        logic [TAG_W-1:0] tag;
        pdma_attr_t attr;
    } pdma_out_t;

    typedef enum logic [1:0] {
        PDMA_IDLE = 2'b00,
        PDMA_MMU = 2'b01,
        PDMA_OUT = 2'b10
    } pdma_state_t;

endpackage

/* sim/pdma_attr_assign_asserts.sv */
// port-level checks for the dma attribute assignment block
`timescale 1ns/1ps
module pdma_attr_assign_asserts (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ioCoherent,
    input wire logic mmuPresent,
    input wire logic ignoreHints,
    input wire logic overrideEnable,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire pdma_attr_pkg::pdma_req_t reqData,
    input wire logic mmuValid,
    input wire pdma_attr_pkg::pdma_out_t mmuData,
    input wire logic mmuReady,
    input wire logic mmuDone,
    input wire pdma_attr_pkg::pdma_attr_t mmuAttr,
    input wire logic outValid,
    input wire pdma_attr_pkg::pdma_out_t outData,
    input wire logic outReady,
    input wire logic writesPending
);
    // ----------------------------------------
    // request and answer relations
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence sTake;
        reqValid && reqReady;
    endsequence
    sequence sMmuDone;
        mmuValid && mmuReady && mmuDone;
    endsequence
    // outData lags outValid by one edge, so attribute checks wait a cycle
    chk_one_flight: assert property (sTake |=> !reqReady)
        else $error("request accepted while busy");
    chk_mmu_input: assert property (sTake ##0 (mmuPresent && !reqData.translated
        && !reqData.noSnoop && !reqData.procHint && reqData.kind == pdma_attr_pkg::KIND_READ)
        |=> mmuValid && mmuData.attr == pdma_attr_pkg::ATTR_INIT)
        else $error("mmu input attributes wrong");
    chk_mmu_result: assert property ((sMmuDone ##0 (mmuAttr.share == pdma_attr_pkg::SH_OUTER
        && !overrideEnable)) |=> outValid ##1 outData.attr == $past(mmuAttr, 2))
        else $error("mmu attributes not taken whole");
    chk_direct_out: assert property ((sTake ##0 (!mmuPresent && !writesPending
        && reqData.kind != pdma_attr_pkg::KIND_MSI)) |=> outValid)
        else $error("no answer after direct request");
    chk_out_stands: assert property (outValid && $past(outValid) && !outReady
        |=> outValid && $stable(outData))
        else $error("output changed before accepted");
    chk_release_idle: assert property (outValid && outReady |=> !outValid && reqReady)
        else $error("no return to idle");
    chk_msi_held: assert property (outValid && $past(outValid) && writesPending
        |-> outData.kind != pdma_attr_pkg::KIND_MSI)
        else $error("msi passed earlier writes");
    chk_msi_attrs: assert property (outValid && $past(outValid) && overrideEnable
        && outData.kind == pdma_attr_pkg::KIND_MSI |-> outData.attr.noMerge
        && !outData.attr.readAlloc && !outData.attr.writeAlloc)
        else $error("msi may merge or allocate");
    chk_nc_outer: assert property (outValid && $past(outValid)
        && outData.attr.innerCache == pdma_attr_pkg::CA_NC
        |-> outData.attr.share == pdma_attr_pkg::SH_OUTER)
        else $error("non-cacheable not outer shareable");
endmodule
bind pdma_attr_assign pdma_attr_assign_asserts pdma_attr_assign_asserts_inst (.*);

/* sim/pdma_attr_assign_test.sv */
// self-checking bench for the dma attribute assignment block
`timescale 1ns/1ps
module pdma_attr_assign_test;
    logic core_clk, sys_rst, ioCoherent, mmuPresent, ignoreHints, overrideEnable;
    logic reqValid, reqReady, mmuValid, mmuReady, mmuDone, outValid, outReady, writesPending;
    logic [3:0] lat;
    pdma_attr_pkg::pdma_req_t reqData;
    pdma_attr_pkg::pdma_out_t mmuData, outData, got;
    pdma_attr_pkg::pdma_attr_t mmuAttr, retAttr, e;
    int err_total, cmp_count;
    pdma_attr_assign pdma_attr_assign_inst (.*);
    pdma_mmu_model pdma_mmu_model_inst (.*);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic run(input int hold);
        int n;
        @(negedge core_clk);
        reqValid = 1'b1;
        @(negedge core_clk);
        reqValid = 1'b0;
        repeat (hold) begin
            @(negedge core_clk);
            chk(outValid, 1'b0, "msi held");
        end
        writesPending = 1'b0;
        n = 0;
        while (outValid !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk(n < 40, 1'b1, "answer");
        @(negedge core_clk);
        outReady = 1'b1;
        got = outData;
        @(negedge core_clk);
        outReady = 1'b0;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_plain();
        reqData = '0;
        reqData.addr = 64'h0000_0012_3456_7890;
        for (int i = 0; i < 2; i++) begin
            ioCoherent = i[0];
            run(0);
            chk(got.attr, pdma_attr_pkg::ATTR_INIT, "initial attr");
            chk(got.addr, reqData.addr, "address");
        end
        ioCoherent = 1'b0;
    endtask
    task automatic t_hint();
        reqData = '0;
        reqData.procHint = 1'b1;
        for (int i = 0; i < 2; i++) begin
            reqData.kind = 2'(i);
            e = pdma_attr_pkg::ATTR_INIT;
            e.readAlloc = (i == 0);
            e.writeAlloc = (i == 1);
            run(0);
            chk(got.attr, e, "alloc hint");
        end
    endtask
    task automatic t_nosnoop_ignore();
        reqData = '0;
        reqData.noSnoop = 1'b1;
        e = pdma_attr_pkg::ATTR_INIT;
        e.innerCache = pdma_attr_pkg::CA_NC;
        e.outerCache = pdma_attr_pkg::CA_NC;
        run(0);
        chk(got.attr, e, "no snoop");
        reqData = '0;
        reqData.translated = 1'b1;
        reqData.hintValid = 1'b1;
        reqData.hintAttr = '0;
        ignoreHints = 1'b1;
        run(0);
        chk(got.attr, pdma_attr_pkg::ATTR_INIT, "ignored hint");
        ignoreHints = 1'b0;
        reqData.hintAttr = retAttr;
        run(0);
        chk(got.attr, retAttr, "applied hint");
    endtask
    task automatic t_mmu();
        reqData = '0;
        mmuPresent = 1'b1;
        for (int i = 0; i < 2; i++) begin
            lat = 4'(i * 3);
            run(0);
            chk(got.attr, retAttr, "mmu attr");
        end
        retAttr.share = pdma_attr_pkg::SH_NON;
        ioCoherent = 1'b1;
        e = retAttr;
        e.share = pdma_attr_pkg::SH_INNER;
        run(0);
        chk(got.attr, e, "coherent share");
        retAttr.share = pdma_attr_pkg::SH_INNER;
        ioCoherent = 1'b0;
        e.share = pdma_attr_pkg::SH_OUTER;
        run(0);
        chk(got.attr, e, "noncoherent share");
        retAttr.share = pdma_attr_pkg::SH_OUTER;
        mmuPresent = 1'b0;
    endtask
    task automatic t_targets();
        e = '{pdma_attr_pkg::MT_DEVICE, pdma_attr_pkg::CA_NC, pdma_attr_pkg::CA_NC,
            pdma_attr_pkg::SH_OUTER, 1'b0, 1'b0, 1'b1};
        overrideEnable = 1'b1;
        reqData = '0;
        reqData.kind = pdma_attr_pkg::KIND_MSI;
        reqData.addr = 64'h0000_0000_0800_0010;
        reqData.procHint = 1'b1;
        writesPending = 1'b1;
        run(3);
        chk(got.attr, e, "msi attr");
        reqData.kind = pdma_attr_pkg::KIND_READ;
        reqData.addr = 64'h0000_0000_4000_0100;
        run(0);
        chk(got.attr, e, "mmio attr");
        overrideEnable = 1'b0;
        reqData = '0;
        reqData.kind = pdma_attr_pkg::KIND_IO;
        reqData.addr = 64'h0000_0000_0000_1234;
        run(0);
        chk(got.addr, 64'h0000_0000_F000_1234, "io addr");
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
    initial begin
        {sys_rst, ioCoherent, mmuPresent, ignoreHints, overrideEnable} = 5'h10;
        {reqValid, outReady, writesPending} = 3'h0;
        reqData = '0;
        lat = 4'h0;
        retAttr = pdma_attr_pkg::ATTR_INIT;
        retAttr.innerCache = pdma_attr_pkg::CA_WT;
        retAttr.outerCache = pdma_attr_pkg::CA_WT;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        t_plain();
        t_hint();
        t_nosnoop_ignore();
        t_mmu();
        t_targets();
        wrap_up();
    end
endmodule

/* sim/pdma_mmu_model.sv */
// behavioural system mmu answering attribute lookups
`timescale 1ns/1ps
module pdma_mmu_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic mmuValid,
    input wire logic [3:0] lat,
    input wire pdma_attr_pkg::pdma_attr_t retAttr,
    output logic mmuReady,
    output logic mmuDone,
    output pdma_attr_pkg::pdma_attr_t mmuAttr
);
    logic [3:0] waitCnt;
    wire logic hit = mmuValid && waitCnt == lat;
    assign mmuReady = hit;
    assign mmuDone = hit;
    // inverted outside the answer cycle so a late sample cannot pass by luck
    assign mmuAttr = hit ? retAttr : ~retAttr;
    always_ff @(posedge core_clk) begin
        if (sys_rst || !mmuValid || hit) begin
            waitCnt <= 4'h0;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule
